// >>> logic/pmsf_top.sv
// Power mode status register with a sticky sleep-entered flag and an event interrupt.
// Assumes a simple register port with one-cycle strobes and read data one cycle later,
// and a level from the power mode logic that is high while the core sleeps.
//
// Operation
// - Flag bit 8 sets on sleep entry.
// - Flag reads zero while active, not entered.
// - Writing one to bit 8 clears flag unless the core still sleeps.
// - Writing zero to bit 8 changes nothing.
// - Register at offset 0x000, read and write.
`timescale 1ns/10ps
`default_nettype none

`include "pmsf_regs.svh"

module pmsf_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sleep_mode_in,
	input wire pmsf_pkg::pmsf_addr_t bus_addr,
	input wire pmsf_pkg::pmsf_data_t bus_wdata,
	input wire logic bus_we,
	input wire logic bus_re,
	output var pmsf_pkg::pmsf_data_t bus_rdata,
	output var logic irq,
	output var logic sleep_entered_flag
);

	import pmsf_pkg::*;

	function automatic logic addr_hit(input pmsf_addr_t addr, input pmsf_addr_t offset);
		addr_hit = (addr == offset);
	endfunction

	logic sleep_sync;
	pmsf_mode_t mode_q;
	logic flag_q;
	logic flag_d;
	logic flag_set;
	logic flag_clr;
	pmsf_evt_t evt_set;
	pmsf_evt_t evt_clr;
	pmsf_evt_t status_q;
	pmsf_evt_t status_d;
	pmsf_evt_t enable_q;
	pmsf_evt_t enable_d;
	pmsf_data_t rdata_d;
	logic wr_pwr;
	logic wr_clear;
	logic wr_enable;

	// The sleep level comes from another part of the chip and is resynchronised first.
	pmsf_sync u_sleep_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(sleep_mode_in),
		.sync_out(sleep_sync)
	);

	assign wr_pwr = bus_we && addr_hit(bus_addr, `PMSF_OFF_PWR_STATUS);
	assign wr_clear = bus_we && addr_hit(bus_addr, `PMSF_OFF_IRQ_CLEAR);
	assign wr_enable = bus_we && addr_hit(bus_addr, `PMSF_OFF_IRQ_ENABLE);

	// Mode tracker; its transitions are the entry and wake events.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= pmsf_mode_active;
		end else begin
			unique case (mode_q)
				pmsf_mode_active: begin
					if (sleep_sync) begin
						mode_q <= pmsf_mode_low;
					end
				end
				pmsf_mode_low: begin
					if (!sleep_sync) begin
						mode_q <= pmsf_mode_active;
					end
				end
				// An upset into a code that is not one-hot falls back to active.
				default: begin
					mode_q <= pmsf_mode_active;
				end
			endcase
		end
	end

	assign evt_set[`PMSF_BIT_EVT_ENTRY] = (mode_q == pmsf_mode_active) && sleep_sync;
	assign evt_set[`PMSF_BIT_EVT_WAKE] = (mode_q == pmsf_mode_low) && !sleep_sync;

	// The flag is set for as long as the core is in a low-power mode.
	assign flag_set = sleep_sync;
	// Only bit 8 of a write matters; the reserved bits are ignored.
	assign flag_clr = wr_pwr && bus_wdata[`PMSF_BIT_SLEEP_FLAG];

	// A set in the same cycle as a clear wins, so an entry is never lost.
	always_comb begin
		flag_d = flag_q;
		if (flag_set) begin
			flag_d = 1'b1;
		end else if (flag_clr) begin
			flag_d = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flag_q <= `PMSF_RST_FLAG;
		end else begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sleep_entered_flag <= `PMSF_RST_FLAG;
		end else begin
			sleep_entered_flag <= flag_d;
		end
	end

	// Sticky event bits, each cleared by writing one to its position.
	generate
		for (genvar i = 0; i < PMSF_EVT_N; i++) begin : g_evt
			assign evt_clr[i] = wr_clear && bus_wdata[i];
			assign status_d[i] = evt_set[i] | (status_q[i] & ~evt_clr[i]);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q <= `PMSF_RST_EVT;
		end else begin
			status_q <= status_d;
		end
	end

	assign enable_d = wr_enable ? bus_wdata[PMSF_EVT_N-1:0] : enable_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable_q <= `PMSF_RST_EVT;
		end else begin
			enable_q <= enable_d;
		end
	end

	// Built from next values so the output tracks the status bits without lag.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_d & enable_d);
		end
	end

	// Read mux; reserved bits and unmapped addresses read as zero.
	always_comb begin
		rdata_d = `PMSF_RST_DATA;
		if (bus_re) begin
			if (addr_hit(bus_addr, `PMSF_OFF_PWR_STATUS)) begin
				rdata_d[`PMSF_BIT_SLEEP_FLAG] = flag_q;
			end else if (addr_hit(bus_addr, `PMSF_OFF_IRQ_STATUS)) begin
				rdata_d[PMSF_EVT_N-1:0] = status_q;
			end else if (addr_hit(bus_addr, `PMSF_OFF_IRQ_ENABLE)) begin
				rdata_d[PMSF_EVT_N-1:0] = enable_q;
			end else if (addr_hit(bus_addr, `PMSF_OFF_MODE_LIVE)) begin
				rdata_d[`PMSF_BIT_MODE_LOW] = (mode_q == pmsf_mode_low);
			end
		end
	end

	// Read data stand for one cycle only, then fall back to zero.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_rdata <= `PMSF_RST_DATA;
		end else begin
			bus_rdata <= rdata_d;
		end
	end

	a_flag_sets: assert property (
		@(posedge clk) disable iff (sys_rst)
		sleep_sync |=> flag_q && sleep_entered_flag)
		else $error("flag not set while core sleeps");

	a_flag_reads_zero: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_re && bus_addr == `PMSF_OFF_PWR_STATUS && !flag_q)
		|=> !bus_rdata[`PMSF_BIT_SLEEP_FLAG])
		else $error("flag read as one while clear");

	a_flag_clears: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_we && bus_addr == `PMSF_OFF_PWR_STATUS && bus_wdata[`PMSF_BIT_SLEEP_FLAG] && !sleep_sync)
		|=> !flag_q && !sleep_entered_flag)
		else $error("write of one did not clear flag");

	a_flag_zero_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_we && bus_addr == `PMSF_OFF_PWR_STATUS && !bus_wdata[`PMSF_BIT_SLEEP_FLAG])
		|=> flag_q == $past(flag_q) || $past(sleep_sync))
		else $error("write of zero changed flag");

	a_flag_read_map: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_re && bus_addr == `PMSF_OFF_PWR_STATUS)
		|=> bus_rdata == {23'h000000, $past(flag_q), 8'h00})
		else $error("power status read data wrong");

	a_flag_holds_wake: assert property (
		@(posedge clk) disable iff (sys_rst)
		($fell(sleep_sync) && !flag_clr) |=> flag_q)
		else $error("flag dropped on wake");

	a_entry_event: assert property (
		@(posedge clk) disable iff (sys_rst)
		$rose(sleep_sync) |=> status_q[`PMSF_BIT_EVT_ENTRY] && mode_q == pmsf_mode_low)
		else $error("entry event not recorded");

	a_irq_level: assert property (
		@(posedge clk) disable iff (sys_rst)
		((status_q & enable_q) != 2'h0) |-> irq)
		else $error("interrupt low with enabled status set");

	a_irq_quiet: assert property (
		@(posedge clk) disable iff (sys_rst)
		((status_q & enable_q) == 2'h0) |-> !irq)
		else $error("interrupt high with no enabled status");

	a_rdata_idle: assert property (
		@(posedge clk) disable iff (sys_rst)
		!bus_re |=> bus_rdata == 32'h0000_0000)
		else $error("read data not zero outside a read");

	a_reserved_zero: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_re && bus_addr == `PMSF_OFF_PWR_STATUS)
		|=> (bus_rdata & 32'hFFFF_FEFF) == 32'h0000_0000)
		else $error("reserved power status bits read as one");

	a_flag_stays_clear: assert property (
		@(posedge clk) disable iff (sys_rst)
		(!flag_q && !sleep_sync) |=> !flag_q)
		else $error("flag set without sleep");

	a_flag_copy: assert property (
		@(posedge clk) disable iff (sys_rst)
		1'b1 |-> sleep_entered_flag == flag_q)
		else $error("flag output differs from register bit");

	a_wake_event: assert property (
		@(posedge clk) disable iff (sys_rst)
		$fell(sleep_sync) |=> status_q[`PMSF_BIT_EVT_WAKE] && mode_q == pmsf_mode_active)
		else $error("wake event not recorded");

	a_evt_clear: assert property (
		@(posedge clk) disable iff (sys_rst)
		(wr_clear && bus_wdata[`PMSF_BIT_EVT_ENTRY] && !evt_set[`PMSF_BIT_EVT_ENTRY])
		|=> !status_q[`PMSF_BIT_EVT_ENTRY])
		else $error("entry event not cleared");

	a_evt_sticky: assert property (
		@(posedge clk) disable iff (sys_rst)
		(status_q[`PMSF_BIT_EVT_ENTRY] && !(wr_clear && bus_wdata[`PMSF_BIT_EVT_ENTRY]))
		|=> status_q[`PMSF_BIT_EVT_ENTRY])
		else $error("entry event dropped without clear");

	a_enable_write: assert property (
		@(posedge clk) disable iff (sys_rst)
		wr_enable |=> enable_q == $past(enable_d))
		else $error("enable write not taken");

	a_enable_hold: assert property (
		@(posedge clk) disable iff (sys_rst)
		!wr_enable |=> $stable(enable_q))
		else $error("enable changed without write");

	a_mode_live: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_re && bus_addr == `PMSF_OFF_MODE_LIVE)
		|=> bus_rdata[`PMSF_BIT_MODE_LOW] == ($past(mode_q) == pmsf_mode_low))
		else $error("live mode read wrong");

	a_unmapped_read: assert property (
		@(posedge clk) disable iff (sys_rst)
		(bus_re && bus_addr > `PMSF_OFF_MODE_LIVE) |=> bus_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

endmodule

`default_nettype wire

// >>> logic/pmsf_regs.svh
// Register offsets, field positions and reset values of the power mode status block.
// Assumes a 12-bit byte address and 32-bit data words on the register port.
`ifndef PMSF_REGS_SVH
`define PMSF_REGS_SVH

`define PMSF_OFF_PWR_STATUS 12'h000
`define PMSF_OFF_IRQ_STATUS 12'h004
`define PMSF_OFF_IRQ_CLEAR 12'h008
`define PMSF_OFF_IRQ_ENABLE 12'h00C
`define PMSF_OFF_MODE_LIVE 12'h010

`define PMSF_BIT_SLEEP_FLAG 8
`define PMSF_BIT_EVT_ENTRY 0
`define PMSF_BIT_EVT_WAKE 1
`define PMSF_BIT_MODE_LOW 0

`define PMSF_RST_FLAG 1'b0
`define PMSF_RST_EVT 2'h0
`define PMSF_RST_DATA 32'h0000_0000

`endif

// >>> logic/pmsf_pkg.sv
// Types shared by the power mode status block.
// Assumes the offsets and field positions come from pmsf_regs.svh.
package pmsf_pkg;

	localparam int PMSF_ADDR_W = 12;
	localparam int PMSF_DATA_W = 32;
	localparam int PMSF_EVT_N = 2;

	typedef logic [PMSF_ADDR_W-1:0] pmsf_addr_t;
	typedef logic [PMSF_DATA_W-1:0] pmsf_data_t;
	typedef logic [PMSF_EVT_N-1:0] pmsf_evt_t;

	typedef enum logic [1:0] {
		pmsf_mode_active = 2'b01,
		pmsf_mode_low = 2'b10
	} pmsf_mode_t;

endpackage

// >>> logic/pmsf_sync.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
// Assumes the input changes slowly compared with the clock.
`timescale 1ns/10ps
`default_nettype none

module pmsf_sync (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic async_in,
	output var logic sync_out
);

	logic meta_q;

	// The first stage is read only by the second stage.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the power mode status block, random and corner cases.
// Assumes the block answers reads one cycle after the strobe and syncs sleep in two flops.
`timescale 1ns/10ps
`default_nettype none

`include "pmsf_regs.svh"

module tb_top;
	import pmsf_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sleep_mode_in = 1'b0;
	pmsf_addr_t bus_addr = '0;
	pmsf_data_t bus_wdata = '0;
	logic bus_we = 1'b0;
	logic bus_re = 1'b0;
	pmsf_data_t bus_rdata;
	logic irq;
	logic sleep_entered_flag;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] rng = 32'h0000_0046;
	logic exp_flag;
	logic [31:0] r;
	pmsf_top uut (.clk(clk), .sys_rst(sys_rst), .sleep_mode_in(sleep_mode_in), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .irq(irq),
		.sleep_entered_flag(sleep_entered_flag));
	always #20 clk = ~clk;
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Sleep sets the flag and wins over a clear written in the same period.
	function automatic logic next_flag(input logic cur, input logic slp, input logic clr);
		return (cur | slp) & ~(clr & ~slp);
	endfunction
	task automatic summarize();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input pmsf_addr_t a, input pmsf_data_t d);
		@(posedge clk);
		bus_we <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_we <= 1'b0;
	endtask
	task automatic rd(input pmsf_addr_t a, input logic [31:0] exp, input string name);
		@(posedge clk);
		bus_re <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_re <= 1'b0;
		#1;
		chk(name, bus_rdata, exp);
	endtask
	task automatic settle(input logic slp);
		@(posedge clk);
		sleep_mode_in <= slp;
		repeat (4) @(posedge clk);
		#1;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0000, "status after reset");
		chk("flag after reset", sleep_entered_flag, 32'h0);
		chk("irq after reset", irq, 32'h0);
		rd(12'h014, 32'h0000_0000, "unmapped read");
		wr(`PMSF_OFF_IRQ_ENABLE, 32'h0000_0003);
		rd(`PMSF_OFF_IRQ_ENABLE, 32'h0000_0003, "irq enable");
		settle(1'b1);
		chk("flag on sleep", sleep_entered_flag, 32'h1);
		chk("irq on sleep", irq, 32'h1);
		rd(`PMSF_OFF_MODE_LIVE, 32'h0000_0001, "mode live sleeping");
		rd(`PMSF_OFF_IRQ_CLEAR, 32'h0000_0000, "clear reads zero");
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0100, "status sleeping");
		wr(`PMSF_OFF_PWR_STATUS, 32'h0000_0100);
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0100, "clear while asleep");
		settle(1'b0);
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0100, "flag after wake");
		rd(`PMSF_OFF_MODE_LIVE, 32'h0000_0000, "mode live awake");
		wr(`PMSF_OFF_PWR_STATUS, 32'h0000_0000);
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0100, "write zero");
		rd(`PMSF_OFF_IRQ_STATUS, 32'h0000_0003, "event status");
		wr(`PMSF_OFF_IRQ_CLEAR, 32'h0000_0003);
		rd(`PMSF_OFF_IRQ_STATUS, 32'h0000_0000, "event cleared");
		chk("irq cleared", irq, 32'h0);
		wr(`PMSF_OFF_PWR_STATUS, 32'h0000_0100);
		#1;
		chk("flag cleared", sleep_entered_flag, 32'h0);
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0000, "status cleared");
		exp_flag = 1'b0;
		for (int i = 0; i < 40; i++) begin
			rng = xorshift(rng);
			r = rng;
			settle(r[0]);
			wr(`PMSF_OFF_PWR_STATUS, {23'h0, r[1], 8'h00});
			exp_flag = next_flag(exp_flag, r[0], r[1]);
			rd(`PMSF_OFF_PWR_STATUS, {23'h0, exp_flag, 8'h00}, "random status");
			chk("random flag", sleep_entered_flag, {31'h0, exp_flag});
		end
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		sleep_mode_in <= 1'b0;
		rd(`PMSF_OFF_PWR_STATUS, 32'h0000_0000, "status after reset");
		summarize();
	end
endmodule

`default_nettype wire
